// ==== hw/bsl_led_top.sv ====
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
// Behaviour
// - Status LED dark without mains/standby power
// - Alternate amber/green during controller initialisation
// - Ignore power button during initialisation
// - Init done re-enables button; booted or a fault ends the init blink
// - Booted, no fault: steady green
// - Degraded conditions blink green
// - Ten or more errors with sparing: degraded
// - Non-fatal alarm conditions blink amber
// - No sparing/mirroring, ten errors: amber blink
// - Fatal conditions give steady amber
// - Per-slot memory fault LED when disabled
// - Post code LEDs hold last code
module bsl_led_top
    import bsl_pkg::*;
#(
    parameter int HALF_CYC = BLINK_HALF_CYC,
    parameter longint INIT_CYC = INIT_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Power presence
    input wire logic mainsOk,
    input wire logic standbyOk,
    // Power button
    input wire logic powerButton,
    output logic powerButtonOut,
    // Memory error counting
    input wire logic corrErrEvent,
    input wire logic errWindowClear,
    // AXI4-Lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Indicators
    output logic ledGreen,
    output logic ledAmber,
    output logic [DIMM_SLOTS-1:0] dimmFaultLed,
    output logic [POST_W-1:0] postCodeLed,
    output logic irq
);
    logic wrEn, rdHit, wrHit, phase;
    logic [7:0] wrAddr, rdAddr;
    logic [31:0] wrData, rdData;
    logic [3:0] wrStrb;
    logic [31:0] ctrl_r, cond_r;
    logic [DIMM_SLOTS-1:0] dimm_r;
    logic [POST_W-1:0] post_r;
    logic [2:0] ists_r, imsk_r;
    logic [3:0] ceCnt_r;
    logic [63:0] initCnt_r;
    logic initDone_r;
    bsl_sev_t sev_r, sevNxt;

    bsl_axil_regs u_regs (
        .mclk(mclk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .wrStrb(wrStrb),
        .rdAddr(rdAddr), .rdData(rdData), .rdHit(rdHit), .wrHit(wrHit)
    );

    bsl_blink_div #(.HALF_CYC(HALF_CYC)) u_blink (
        .mclk(mclk), .rst(rst), .phase(phase)
    );

    function automatic logic [31:0] bsl_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : bsl_merge

    // Decode
    wire wCtrl = wrEn && (wrAddr == OFS_CTRL);
    wire wCond = wrEn && (wrAddr == OFS_COND);
    wire wDimm = wrEn && (wrAddr == OFS_DIMM);
    wire wPost = wrEn && (wrAddr == OFS_POST);
    wire wIsts = wrEn && (wrAddr == OFS_ISTS);
    wire wImsk = wrEn && (wrAddr == OFS_IMSK);
    assign wrHit = wCtrl || wCond || wDimm || wPost || wIsts || wImsk;

    wire powered = mainsOk && standbyOk;
    wire [31:0] ctrlNew = bsl_merge(ctrl_r, wrData, wrStrb);
    wire [31:0] condNew = bsl_merge(cond_r, wrData, wrStrb);
    wire [31:0] dimmNew = bsl_merge(32'(dimm_r), wrData, wrStrb);
    wire [31:0] postNew = bsl_merge(32'(post_r), wrData, wrStrb);
    wire [31:0] statWord = {16'h0, 4'(ceCnt_r), 5'h0, 3'(sev_r), 3'h0, initDone_r};
    wire noRedundancy = !ctrl_r[CTRL_SPARING] && !ctrl_r[CTRL_MIRRORING];
    wire ceOver = (ceCnt_r >= CE_LIMIT);
    wire ceDegr = ceOver && ctrl_r[CTRL_SPARING];
    wire ceNoncrit = ceOver && noRedundancy;
    wire anyFatal = |(cond_r & FATAL_MASK);
    wire anyNoncrit = (|(cond_r & NONCRIT_MASK)) || ceNoncrit;
    wire anyDegr = (|(cond_r & DEGRADED_MASK)) || ceDegr;
    wire initTimeout = (initCnt_r == 64'(INIT_CYC - 1));
    wire initFinish = !initDone_r && powered && (ctrl_r[CTRL_INIT_DONE] || initTimeout);
    wire btnDropped = powerButton && !initDone_r;
    wire [2:0] evts = {sevNxt != sev_r, btnDropped, initFinish};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            cond_r <= 32'h0;
            dimm_r <= '0;
            post_r <= '0;
            imsk_r <= 3'h0;
        end else begin
            if (wCtrl) ctrl_r <= ctrlNew;
            // Firmware flags go stale once mains drops; force a fresh init
            if (!powered) begin
                ctrl_r[CTRL_INIT_DONE] <= 1'b0;
                ctrl_r[CTRL_BOOTED] <= 1'b0;
            end
            if (wCond) cond_r <= condNew;
            if (wDimm) dimm_r <= dimmNew[DIMM_SLOTS-1:0];
            if (wPost) post_r <= postNew[POST_W-1:0];
            if (wImsk) imsk_r <= wrData[2:0];
        end
    end

    // Sticky status: set wins over write-one clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ists_r <= 3'h0;
        end else begin
            ists_r <= (ists_r & ~(wIsts ? wrData[2:0] : 3'h0)) | evts;
        end
    end

    // Correctable error counter, saturating, cleared per window
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ceCnt_r <= 4'h0;
        end else if (errWindowClear) begin
            ceCnt_r <= 4'h0;
        end else if (corrErrEvent && ceCnt_r != 4'hf) begin
            ceCnt_r <= ceCnt_r + 4'h1;
        end
    end

    // Initialisation phase tracking
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            initCnt_r <= 64'h0;
            initDone_r <= 1'b0;
        end else if (!powered) begin
            initCnt_r <= 64'h0;
            initDone_r <= 1'b0;
        end else if (initFinish) begin
            initDone_r <= 1'b1;
        end else if (!initDone_r) begin
            initCnt_r <= initCnt_r + 64'h1;
        end
    end

    // Severity selection, most severe first
    always_comb begin
        if (!powered) begin
            sevNxt = SEV_OFF;
        end else if (!initDone_r) begin
            sevNxt = SEV_INIT;
        end else if (anyFatal) begin
            sevNxt = SEV_FATAL;
        end else if (anyNoncrit) begin
            sevNxt = SEV_NONCRIT;
        end else if (anyDegr) begin
            sevNxt = SEV_DEGR;
        end else if (ctrl_r[CTRL_BOOTED]) begin
            sevNxt = SEV_OK;
        end else begin
            sevNxt = SEV_INIT;
        end
    end

    // Read mux
    assign rdHit = (rdAddr == OFS_CTRL) || (rdAddr == OFS_COND) || (rdAddr == OFS_DIMM) ||
                   (rdAddr == OFS_POST) || (rdAddr == OFS_STAT) || (rdAddr == OFS_ISTS) ||
                   (rdAddr == OFS_IMSK);
    assign rdData = (rdAddr == OFS_CTRL) ? ctrl_r :
                    (rdAddr == OFS_COND) ? cond_r :
                    (rdAddr == OFS_DIMM) ? 32'(dimm_r) :
                    (rdAddr == OFS_POST) ? 32'(post_r) :
                    (rdAddr == OFS_STAT) ? statWord :
                    (rdAddr == OFS_ISTS) ? 32'(ists_r) :
                    (rdAddr == OFS_IMSK) ? 32'(imsk_r) : 32'h0;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sev_r <= SEV_OFF;
            ledGreen <= 1'b0;
            ledAmber <= 1'b0;
            dimmFaultLed <= '0;
            postCodeLed <= '0;
            powerButtonOut <= 1'b0;
            irq <= 1'b0;
        end else begin
            sev_r <= sevNxt;
            case (sevNxt)
                SEV_INIT: begin
                    ledGreen <= phase;
                    ledAmber <= !phase;
                end
                SEV_OK: begin
                    ledGreen <= 1'b1;
                    ledAmber <= 1'b0;
                end
                SEV_DEGR: begin
                    ledGreen <= phase;
                    ledAmber <= 1'b0;
                end
                SEV_NONCRIT: begin
                    ledGreen <= 1'b0;
                    ledAmber <= phase;
                end
                SEV_FATAL: begin
                    ledGreen <= 1'b0;
                    ledAmber <= 1'b1;
                end
                default: begin
                    ledGreen <= 1'b0;
                    ledAmber <= 1'b0;
                end
            endcase
            dimmFaultLed <= dimm_r;
            postCodeLed <= post_r;
            powerButtonOut <= powerButton && initDone_r;
            irq <= |(ists_r & imsk_r);
        end
    end

    property p_dark_unpowered;
        @(posedge mclk) disable iff (rst) !powered |=> (!ledGreen && !ledAmber);
    endproperty
    a_dark_unpowered: assert property (p_dark_unpowered) else $error("LED lit unpowered");

    property p_init_alt;
        @(posedge mclk) disable iff (rst) (powered && !initDone_r) |=> (ledGreen != ledAmber);
    endproperty
    a_init_alt: assert property (p_init_alt) else $error("Init not alternating");

    property p_btn_block;
        @(posedge mclk) disable iff (rst) !initDone_r |=> !powerButtonOut;
    endproperty
    a_btn_block: assert property (p_btn_block) else $error("Button passed in init");

    property p_btn_pass;
        @(posedge mclk) disable iff (rst) (initDone_r && powerButton) |=> powerButtonOut;
    endproperty
    a_btn_pass: assert property (p_btn_pass) else $error("Button not passed");

    property p_ok_green;
        @(posedge mclk) disable iff (rst) (sevNxt == SEV_OK) |=> (ledGreen && !ledAmber);
    endproperty
    a_ok_green: assert property (p_ok_green) else $error("Not steady green");

    property p_fatal_amber;
        @(posedge mclk) disable iff (rst)
            (powered && initDone_r && anyFatal) |=> (ledAmber && !ledGreen);
    endproperty
    a_fatal_amber: assert property (p_fatal_amber) else $error("Fatal not amber");

    property p_degr_noamber;
        @(posedge mclk) disable iff (rst)
            (powered && initDone_r && anyDegr && !anyNoncrit && !anyFatal) |=> !ledAmber;
    endproperty
    a_degr_noamber: assert property (p_degr_noamber) else $error("Degraded shows amber");

    property p_dimm_led;
        @(posedge mclk) disable iff (rst) wDimm |=> ##1 (dimmFaultLed == $past(dimmNew[5:0], 2));
    endproperty
    a_dimm_led: assert property (p_dimm_led) else $error("DIMM LED wrong");

    property p_post_hold;
        @(posedge mclk) disable iff (rst)
            (!$past(wPost) && !$past(wPost, 2)) |-> $stable(postCodeLed);
    endproperty
    a_post_hold: assert property (p_post_hold) else $error("Post code changed");
endmodule : bsl_led_top

// ==== hw/bsl_pkg.sv ====
package bsl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COND = 8'h04;
    localparam logic [7:0] OFS_DIMM = 8'h08;
    localparam logic [7:0] OFS_POST = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_ISTS = 8'h14;
    localparam logic [7:0] OFS_IMSK = 8'h18;
    // CTRL fields
    localparam int CTRL_INIT_DONE = 0;
    localparam int CTRL_BOOTED = 1;
    localparam int CTRL_SPARING = 2;
    localparam int CTRL_MIRRORING = 3;
    // COND fields: degraded 0..6, non-critical 8..10, fatal 16..24
    localparam int C_MEM_PARTIAL = 0;
    localparam int C_REDUND_LOST = 1;
    localparam int C_PCIE_ERR = 2;
    localparam int C_CPU_ONE_FAIL = 3;
    localparam int C_FAN_FAIL = 4;
    localparam int C_NONCRIT_THRESH = 5;
    localparam int C_MIRROR_LOST = 6;
    localparam int C_CRIT_VOLT = 8;
    localparam int C_VOLTAGE_REGULATOR_OVERHEAT = 9;
    localparam int C_FANS_BELOW_MIN = 10;
    localparam int C_SOLE_DIMM_FAIL = 16;
    localparam int C_UNCORR_NONRED = 17;
    localparam int C_PROCESSOR_INTERNAL_ERROR = 18;
    localparam int C_CPU1_ABSENT = 19;
    localparam int C_PROCESSOR_THERMAL_TRIP = 20;
    localparam int C_MEMORY_TEMPERATURE_HIGH = 21;
    localparam int C_CRIT_TEMP = 22;
    localparam int C_POWER_FAULT = 23;
    localparam int C_CPU_CFG_MISMATCH = 24;
    localparam logic [31:0] DEGRADED_MASK = 32'h0000007f;
    localparam logic [31:0] NONCRIT_MASK = 32'h00000700;
    localparam logic [31:0] FATAL_MASK = 32'h01ff0000;
    // Sizes and resets
    localparam int DIMM_SLOTS = 6;
    localparam int POST_W = 8;
    localparam logic [3:0] CE_LIMIT = 4'h a;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [2:0] ISTS_INIT_DONE = 3'h1;
    localparam logic [2:0] ISTS_BTN_DROPPED = 3'h2;
    localparam logic [2:0] ISTS_SEV_CHANGE = 3'h4;
    // Timing
    localparam int CLK_HZ = 200_000_000;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int INIT_TIMEOUT_S = 20;
    localparam longint INIT_TIMEOUT_CYC = longint'(CLK_HZ) * INIT_TIMEOUT_S;
    typedef enum logic [2:0] {SEV_OFF, SEV_INIT, SEV_OK, SEV_DEGR, SEV_NONCRIT, SEV_FATAL}
        bsl_sev_t;
endpackage : bsl_pkg

// ==== hw/bsl_blink_div.sv ====
`timescale 1ns/100ps
module bsl_blink_div
    import bsl_pkg::*;
#(
    parameter int HALF_CYC = BLINK_HALF_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Blink phase
    output logic phase
);
    logic [31:0] cnt_r;
    wire cntEnd = (cnt_r == 32'(HALF_CYC - 1));
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= 32'h0;
            phase <= 1'b0;
        end else if (cntEnd) begin
            cnt_r <= 32'h0;
            phase <= ~phase;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end
endmodule : bsl_blink_div

// ==== hw/bsl_axil_regs.sv ====
`timescale 1ns/100ps
module bsl_axil_regs
    import bsl_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AXI4-Lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register side
    output logic wrEn,
    output logic [7:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    output logic [7:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdHit,
    input wire logic wrHit
);
    logic awHeld_r, wHeld_r;
    logic [7:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign wrEn = doWrite;
    assign wrAddr = awAddr_r;
    assign wrData = wData_r;
    assign wrStrb = wStrb_r;
    assign rdAddr = s_axi_araddr;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h0;
            wData_r <= 32'h0;
            wStrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !awHeld_r && !awTake;
            s_axi_wready <= !wHeld_r && !wTake;
            if (awTake) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (wTake) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdHit ? rdData : 32'h0;
                s_axi_rresp <= rdHit ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : bsl_axil_regs

// ==== dv/bsl_panel_model.sv ====
`timescale 1ns/100ps
module bsl_panel_model (
    // Clock and control
    input wire logic mclk,
    input wire logic clr,
    // Front indicators
    input wire logic ledGreen,
    input wire logic ledAmber,
    // Lit-cycle tallies and window cycle count
    output int gOn,
    output int aOn,
    output int nCyc
);
    // Counts lit cycles of each colour over a window
    always @(posedge mclk) begin
        if (clr) begin
            gOn <= 0;
            aOn <= 0;
            nCyc <= 0;
        end else begin
            gOn <= gOn + int'(ledGreen === 1'h1);
            aOn <= aOn + int'(ledAmber === 1'h1);
            nCyc <= nCyc + 1;
        end
    end
endmodule : bsl_panel_model

// ==== dv/board_status_led_indicator_bench.sv ====
`timescale 1ns/100ps
module board_status_led_indicator_bench
    import bsl_pkg::*;
;
    localparam int HALF = 4;
    logic mclk = 1'h0, rst = 1'h1, mainsOk = 1'h0, standbyOk = 1'h0, powerButton = 1'h0;
    logic corrErrEvent = 1'h0, errWindowClear = 1'h0, clr = 1'h1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, post;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, ledGreen, ledAmber, btnOut, irq;
    logic [1:0] bresp, rresp;
    logic [5:0] dimm;
    int gOn, aOn, nCyc, err_total = 0, n_checks = 0;

    always #2.5 mclk = ~mclk;

    bsl_led_top #(.HALF_CYC(HALF), .INIT_CYC(50)) dut_u (
        .mclk(mclk), .rst(rst), .mainsOk(mainsOk), .standbyOk(standbyOk),
        .powerButton(powerButton), .powerButtonOut(btnOut),
        .corrErrEvent(corrErrEvent), .errWindowClear(errWindowClear),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ledGreen(ledGreen),
        .ledAmber(ledAmber), .dimmFaultLed(dimm), .postCodeLed(post), .irq(irq)
    );

    bsl_panel_model panel_u (
        .mclk(mclk), .clr(clr), .ledGreen(ledGreen), .ledAmber(ledAmber),
        .gOn(gOn), .aOn(aOn), .nCyc(nCyc)
    );

    task automatic stop_test;
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_led(input bsl_sev_t got, input bsl_sev_t exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s pattern %0d exp %0d", $time, what, got, exp);
        end
    endtask : chk_led

    // Write: address and data offered together, each released once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit awd, wd, done;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(negedge mclk);
            awd = awvalid & awready;
            wd = wvalid & wready;
            done = bvalid & bready;
            r = bresp;
            @(posedge mclk);
            if (awd) awvalid <= 1'h0;
            if (wd) wvalid <= 1'h0;
            if (done) bready <= 1'h0;
        end while (!done);
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ad, done;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(negedge mclk);
            ad = arvalid & arready;
            done = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge mclk);
            if (ad) arvalid <= 1'h0;
            if (done) rready <= 1'h0;
        end while (!done);
    endtask : axr

    // Classifies the indicator over four blink periods
    task automatic look(output bsl_sev_t s);
        repeat (3) @(posedge mclk);
        clr <= 1'h1;
        @(posedge mclk);
        clr <= 1'h0;
        repeat (8 * HALF) @(posedge mclk);
        @(negedge mclk);
        if (gOn == 0 && aOn == 0) s = SEV_OFF;
        else if (gOn == nCyc && aOn == 0) s = SEV_OK;
        else if (aOn == nCyc && gOn == 0) s = SEV_FATAL;
        else if (aOn == 0 && 2 * gOn == nCyc) s = SEV_DEGR;
        else if (gOn == 0 && 2 * aOn == nCyc) s = SEV_NONCRIT;
        else if (2 * gOn == nCyc && 2 * aOn == nCyc) s = SEV_INIT;
        else s = bsl_sev_t'(3'h7);
    endtask : look

    task automatic pulse_err(input int k);
        repeat (k) begin
            @(posedge mclk);
            corrErrEvent <= 1'h1;
            @(posedge mclk);
            corrErrEvent <= 1'h0;
        end
    endtask : pulse_err

    function automatic bsl_sev_t exp_sev(logic [31:0] c, logic [31:0] ctl, int cnt);
        logic over;
        over = cnt >= int'(CE_LIMIT);
        if ((c & FATAL_MASK) != 0) return SEV_FATAL;
        if ((c & NONCRIT_MASK) != 0 || (over && !ctl[CTRL_SPARING] && !ctl[CTRL_MIRRORING]))
            return SEV_NONCRIT;
        if ((c & DEGRADED_MASK) != 0 || (over && ctl[CTRL_SPARING])) return SEV_DEGR;
        return SEV_OK;
    endfunction : exp_sev

    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        stop_test();
    end

    initial begin
        bsl_sev_t s;
        logic [31:0] d, m, c;
        logic [1:0] r;
        logic [2:0] k;
        void'($urandom(5659));
        repeat (12) @(posedge mclk);
        rst <= 1'h0;
        look(s);
        chk_led(s, SEV_OFF, "no mains");
        @(posedge mclk);
        mainsOk <= 1'h1;
        look(s);
        chk_led(s, SEV_OFF, "no standby");
        @(posedge mclk);
        standbyOk <= 1'h1;
        powerButton <= 1'h1;
        look(s);
        chk_led(s, SEV_INIT, "init blink");
        chk_word(btnOut, 32'h0, "button during init");
        axw(OFS_CTRL, 32'h3, r);
        powerButton <= 1'h0;
        look(s);
        chk_led(s, SEV_OK, "booted");
        @(posedge mclk);
        powerButton <= 1'h1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk_word(btnOut, 32'h1, "button after init");
        axr(OFS_ISTS, d, r);
        powerButton <= 1'h0;
        chk_word(d & 32'h3, 32'h3, "event status");
        @(negedge mclk);
        chk_word(irq, 32'h0, "irq masked");
        axw(OFS_IMSK, 32'h2, r);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk_word(irq, 32'h1, "irq raised");
        axw(OFS_ISTS, 32'h2, r);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk_word(irq, 32'h0, "irq cleared");
        axw(8'h40, 32'h1, r);
        chk_word(r, 32'h2, "unmapped write");
        axr(8'h40, d, r);
        chk_word({d[29:0], r}, 32'h2, "unmapped read");
        m = DEGRADED_MASK | NONCRIT_MASK | FATAL_MASK;
        for (int b = 0; b < 32; b++) begin
            if (m[b]) begin
                axw(OFS_COND, 32'h1 << b, r);
                look(s);
                chk_led(s, exp_sev(32'h1 << b, 32'h3, 0), "single");
            end
        end
        for (int i = 0; i < 12; i++) begin
            k = 3'($urandom_range(7, 1));
            c = $urandom & (({32{k[0]}} & DEGRADED_MASK) | ({32{k[1]}} & NONCRIT_MASK)
                | ({32{k[2]}} & FATAL_MASK));
            axw(OFS_COND, c, r);
            look(s);
            chk_led(s, exp_sev(c, 32'h3, 0), "mixed");
        end
        axw(OFS_COND, 32'h0, r);
        pulse_err(9);
        axr(OFS_STAT, d, r);
        chk_word(d[15:12], 32'h9, "error count");
        look(s);
        chk_led(s, SEV_OK, "below limit");
        pulse_err(1);
        look(s);
        chk_led(s, exp_sev(0, 32'h3, 10), "limit no spare");
        @(posedge mclk);
        errWindowClear <= 1'h1;
        @(posedge mclk);
        errWindowClear <= 1'h0;
        axw(OFS_CTRL, 32'h7, r);
        pulse_err(10);
        look(s);
        chk_led(s, exp_sev(0, 32'h7, 10), "limit spare");
        for (int i = 0; i < 3; i++) begin
            c = $urandom;
            axw(OFS_DIMM, c & 32'h3f, r);
            axw(OFS_POST, c >> 8 & 32'hff, r);
            repeat (4) @(posedge mclk);
            @(negedge mclk);
            chk_word(dimm, c & 32'h3f, "slot leds");
            chk_word(post, c >> 8 & 32'hff, "post code");
        end
        @(posedge mclk);
        mainsOk <= 1'h0;
        look(s);
        chk_led(s, SEV_OFF, "mains lost");
        @(posedge mclk);
        mainsOk <= 1'h1;
        look(s);
        chk_led(s, SEV_INIT, "init restart");
        repeat (60) @(posedge mclk);
        axr(OFS_STAT, d, r);
        chk_word(d[0], 32'h1, "init timeout");
        stop_test();
    end
endmodule : board_status_led_indicator_bench
